// ---- verilog/front_panel_indicator_control.v ----
// Front panel indicator, loop timeout and transmit clock control
//
// The register offsets and the address-and-strobe port were decided locally.
`include "panel_defs.vh"
module front_panel_indicator_control (
   input wire CLK,
   input wire RESETN,
   input wire [3:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire LINK_UP,
   input wire SLOT_ACTIVE,
   input wire TX_BIT,
   input wire RX_BIT,
   input wire BLUE_ALARM,
   input wire YELLOW_ALARM,
   input wire OUT_OF_FRAME,
   input wire SYNC_LOSS,
   input wire FRAME_LOSS,
   input wire FRAMING_BIT_ERR,
   input wire EXCESS_ZEROS,
   input wire CTRL_SLIP,
   input wire SEVERE_FRAME_ERR,
   input wire PATTERN_SENDING,
   input wire PATTERN_MISMATCH,
   input wire ERR_INSERT,
   input wire LOCAL_LOOP,
   input wire REMOTE_LOOP,
   input wire REMOTE_LOOPUP,
   input wire TERM_LOOP_START,
   input wire TERM_LOOP_END,
   input wire EXT_TX_CLK,
   input wire OWN_TX_CLK,
   output reg LINK_LED,
   output reg TX_GREEN,
   output reg TX_ORANGE,
   output reg RX_GREEN,
   output reg RX_ORANGE,
   output reg ALARM_LED,
   output reg ERROR_LED,
   output reg TEST_LED,
   output reg TERM_LOOP_ACTIVE,
   output wire TX_SAMPLE_CLK,
   output wire TX_CLK_OUT
);
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_n;
   wire tick;
   reg [9:0] blink_ms_reg;
   reg [9:0] alarm_ms_reg;
   reg [5:0] cfg_reg;
   reg [15:0] err_count_reg;
   reg [15:0] min_ms_reg;
   reg [7:0] loop_min_reg;
   reg [7:0] limit_min;
   reg err_prev_reg;
   reg alarm_phase_reg;
   wire err_cond;
   wire err_event;
   wire clear_cmd;
   wire defaults_cmd;
   wire half_blink;
   wire sec_pulse;
   wire brief;
   wire no_timeout_setting;
   wire any_alarm;
   wire [1:0] lane_bit;
   wire [1:0] lane_green;
   wire [1:0] lane_orange;
   genvar lane;

   // Reset release is synchronised so every flop behind rst_n leaves reset on the same edge
   always @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   tick_divider u_tick (
      .clk(CLK),
      .rst_n(rst_n),
      .tick(tick)
   );

   // Minute codes to minutes; no_timeout_setting maps to zero and is gated separately
   function [7:0] code_to_min;
      input [3:0] code;
      begin
         case (code)
            `TO_5: code_to_min = 8'h05;
            `TO_10: code_to_min = 8'h0A;
            `TO_15: code_to_min = 8'h0F;
            `TO_30: code_to_min = 8'h1E;
            `TO_45: code_to_min = 8'h2D;
            `TO_60: code_to_min = 8'h3C;
            `TO_90: code_to_min = 8'h5A;
            `TO_120: code_to_min = 8'h78;
            `TO_180: code_to_min = 8'hB4;
            default: code_to_min = 8'h00;
         endcase
      end
   endfunction

   // Address compare shared by the write decode and the read mux
   function addr_is;
      input [3:0] addr;
      input [3:0] target;
      begin
         addr_is = (addr == target);
      end
   endfunction

   // One second blink frame built from the millisecond tick
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         blink_ms_reg <= 10'h000;
      else if (tick)
      begin
         if (blink_ms_reg == (`ONE_SEC_MS - 1))
            blink_ms_reg <= 10'h000;
         else
            blink_ms_reg <= blink_ms_reg + 10'h001;
      end
   end
   assign brief = (blink_ms_reg < `PULSE_MS);
   assign sec_pulse = brief;

   // Alarm blink keeps its own count, so the on-phase shows as soon as an alarm appears
   assign any_alarm = BLUE_ALARM || YELLOW_ALARM || OUT_OF_FRAME || SYNC_LOSS || FRAME_LOSS;
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         alarm_ms_reg <= 10'h000;
      else if (!any_alarm)
         alarm_ms_reg <= 10'h000;
      else if (tick)
      begin
         if (alarm_ms_reg == (`ONE_SEC_MS - 1))
            alarm_ms_reg <= 10'h000;
         else
            alarm_ms_reg <= alarm_ms_reg + 10'h001;
      end
   end
   assign half_blink = (alarm_ms_reg < `HALF_SEC_MS);

   // Phase idles high, matching the cleared count
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         alarm_phase_reg <= 1'b1;
      else
         alarm_phase_reg <= half_blink;
   end

   assign defaults_cmd = WR && addr_is(ADDR, `ADDR_COMMAND) && WDATA[`CMD_DEFAULTS];
   assign clear_cmd = WR && addr_is(ADDR, `ADDR_COMMAND) && WDATA[`CMD_CLEAR_ERR];

   // Header lines and password live outside this block, so defaults cannot touch them
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         cfg_reg <= `CFG_RESET;
      else if (defaults_cmd)
         cfg_reg <= `CFG_RESET;
      else if (WR && addr_is(ADDR, `ADDR_CONFIG))
         cfg_reg <= WDATA[5:0];
   end

   // Error conditions; injected errors alone are shown on the one second beat
   assign err_cond = FRAMING_BIT_ERR || EXCESS_ZEROS || CTRL_SLIP
      || SEVERE_FRAME_ERR;
   assign err_event = err_cond || (PATTERN_SENDING && PATTERN_MISMATCH);

   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         err_prev_reg <= 1'b0;
      else
         err_prev_reg <= err_event;
   end

   // Counter counts onsets; a new onset in the clear cycle still lands
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         err_count_reg <= 16'h0000;
      else if (err_event && !err_prev_reg)
      begin
         if (clear_cmd)
            err_count_reg <= 16'h0001;
         else if (err_count_reg != 16'hFFFF)
            err_count_reg <= err_count_reg + 16'h0001;
      end
      else if (clear_cmd)
         err_count_reg <= 16'h0000;
   end

   // Terminal loop timer; lead and switch loops no_timeout_setting enter it
   assign no_timeout_setting = (cfg_reg[3:0] == `TO_NO_TIMEOUT_SETTING);
   always @*
   begin
      limit_min = code_to_min(cfg_reg[3:0]);
   end

   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         TERM_LOOP_ACTIVE <= 1'b0;
         min_ms_reg <= 16'h0000;
         loop_min_reg <= 8'h00;
      end
      else if (TERM_LOOP_START)
      begin
         TERM_LOOP_ACTIVE <= 1'b1;
         min_ms_reg <= 16'h0000;
         loop_min_reg <= 8'h00;
      end
      else if (TERM_LOOP_ACTIVE)
      begin
         if (TERM_LOOP_END)
            TERM_LOOP_ACTIVE <= 1'b0;
         else if (!no_timeout_setting && (loop_min_reg >= limit_min))
            TERM_LOOP_ACTIVE <= 1'b0;
         else if (tick)
         begin
            if (min_ms_reg == (`TICKS_PER_MIN - 1))
            begin
               min_ms_reg <= 16'h0000;
               if (loop_min_reg != 8'hFF)
                  loop_min_reg <= loop_min_reg + 8'h01;
            end
            else
               min_ms_reg <= min_ms_reg + 16'h0001;
         end
      end
   end

   // Transmit clock steering toward the DTE
   assign TX_SAMPLE_CLK = cfg_reg[`CFG_TXCLK_SEL] ? OWN_TX_CLK : EXT_TX_CLK;
   assign TX_CLK_OUT = OWN_TX_CLK ^ cfg_reg[`CFG_TXCLK_INV];

   // Both bit lanes share one colour rule, so one body serves transmit and receive
   assign lane_bit = {RX_BIT, TX_BIT};
   generate
      for (lane = 0; lane < 2; lane = lane + 1)
      begin : g_lane
         assign lane_green[lane] = SLOT_ACTIVE && lane_bit[lane];
         assign lane_orange[lane] = SLOT_ACTIVE && !lane_bit[lane];
      end
   endgenerate

   // Indicator outputs, all registered
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         LINK_LED <= 1'b0;
         TX_GREEN <= 1'b0;
         TX_ORANGE <= 1'b0;
         RX_GREEN <= 1'b0;
         RX_ORANGE <= 1'b0;
         ALARM_LED <= 1'b0;
         ERROR_LED <= 1'b0;
         TEST_LED <= 1'b0;
      end
      else
      begin
         LINK_LED <= LINK_UP;
         TX_GREEN <= lane_green[0];
         TX_ORANGE <= lane_orange[0];
         RX_GREEN <= lane_green[1];
         RX_ORANGE <= lane_orange[1];
         ALARM_LED <= any_alarm && alarm_phase_reg;
         if (err_cond)
            ERROR_LED <= 1'b1;
         else if (PATTERN_SENDING && PATTERN_MISMATCH)
            ERROR_LED <= 1'b1;
         else if (ERR_INSERT)
            ERROR_LED <= sec_pulse;
         else
            ERROR_LED <= 1'b0;
         // Steady modes win over the loop blink patterns
         if (PATTERN_SENDING || REMOTE_LOOPUP)
            TEST_LED <= 1'b1;
         else if (REMOTE_LOOP)
            TEST_LED <= !brief;
         else if (LOCAL_LOOP)
            TEST_LED <= brief;
         else
            TEST_LED <= 1'b0;
      end
   end

   // Register read port; unmapped addresses read zero
   always @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         RDATA <= 8'h00;
      else if (RD)
      begin
         if (addr_is(ADDR, `ADDR_CONFIG))
            RDATA <= {2'b00, cfg_reg};
         else if (addr_is(ADDR, `ADDR_STATUS))
            RDATA <= {TERM_LOOP_ACTIVE, TEST_LED, ERROR_LED, ALARM_LED, 3'b000, LINK_LED};
         else if (addr_is(ADDR, `ADDR_ERRCNT))
            RDATA <= err_count_reg[7:0];
         else if (addr_is(ADDR, `ADDR_LOOPLEFT))
            RDATA <= loop_min_reg;
         else
            RDATA <= 8'h00;
      end
      else
         RDATA <= 8'h00;
   end
endmodule // front_panel_indicator_control

// ---- verilog/panel_defs.vh ----
// Constants for the front panel indicator controller
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH
`define CLK_HZ 20000000
`define TICK_HZ 1000
`define TICK_DIV (`CLK_HZ / `TICK_HZ)
`define HALF_SEC_MS 500
`define ONE_SEC_MS 1000
`define PULSE_MS 100
`define TICKS_PER_MIN 60000
`define ADDR_CONFIG 4'h0
`define ADDR_COMMAND 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_ERRCNT 4'h3
`define ADDR_LOOPLEFT 4'h4
`define CFG_TIMEOUT_LSB 0
`define CFG_TXCLK_SEL 4
`define CFG_TXCLK_INV 5
`define CMD_DEFAULTS 0
`define CMD_CLEAR_ERR 1
`define TO_5 4'h0
`define TO_10 4'h1
`define TO_15 4'h2
`define TO_30 4'h3
`define TO_45 4'h4
`define TO_60 4'h5
`define TO_90 4'h6
`define TO_120 4'h7
`define TO_180 4'h8
`define TO_NO_TIMEOUT_SETTING 4'h9
`define CFG_RESET 6'h03
`endif

// ---- verilog/tick_divider.v ----
// Divides the system clock into a one-cycle millisecond tick
`include "panel_defs.vh"
module tick_divider (
   input wire clk,
   input wire rst_n,
   output reg tick
);
   reg [14:0] count_reg;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= 15'h0000;
         tick <= 1'b0;
      end
      else if (count_reg == (`TICK_DIV - 1))
      begin
         count_reg <= 15'h0000;
         tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 15'h0001;
         tick <= 1'b0;
      end
   end
endmodule // tick_divider

// ---- testbench/panel_checker_assertions.sv ----
// Port checks for the front panel indicator controller
module panel_checker (
   input wire CLK,
   input wire RESETN,
   input wire WR,
   input wire LINK_UP,
   input wire SLOT_ACTIVE,
   input wire TX_BIT,
   input wire CTRL_SLIP,
   input wire PATTERN_SENDING,
   input wire REMOTE_LOOPUP,
   input wire TERM_LOOP_START,
   input wire TERM_LOOP_END,
   input wire OWN_TX_CLK,
   input wire LINK_LED,
   input wire TX_GREEN,
   input wire TX_ORANGE,
   input wire RX_GREEN,
   input wire RX_ORANGE,
   input wire ERROR_LED,
   input wire TEST_LED,
   input wire TERM_LOOP_ACTIVE,
   input wire TX_CLK_OUT,
   input wire [3:0] ADDR,
   input wire [7:0] WDATA
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [2:0] up_reg;
   reg [5:0] cfg_reg;
   // Internal reset ends two edges late, so checks wait for the third
   always @(posedge CLK or negedge RESETN)
      if (!RESETN)
      begin
         up_reg <= 3'h0;
         cfg_reg <= 6'h03;
      end
      else
      begin
         up_reg <= {up_reg[1:0], 1'h1};
         if (WR && ADDR == 4'h0)
            cfg_reg <= WDATA[5:0];
         else if (WR && ADDR == 4'h1 && WDATA[0])
            cfg_reg <= 6'h03;
      end
   default clocking @(posedge CLK); endclocking
   default disable iff (!up_reg[2]);
   sequence s_loop_go;
      TERM_LOOP_START ##1 TERM_LOOP_ACTIVE;
   endsequence
   chk_link_follow: assert property (##1 LINK_LED == $past(LINK_UP))
      else $error("link led");
   chk_tx_one: assert property (SLOT_ACTIVE && TX_BIT |=> TX_GREEN && !TX_ORANGE)
      else $error("tx one");
   chk_tx_dark: assert property (!SLOT_ACTIVE |=> !TX_GREEN && !TX_ORANGE)
      else $error("tx dark");
   chk_rx_dark: assert property (!SLOT_ACTIVE |=> !RX_GREEN && !RX_ORANGE)
      else $error("rx dark");
   chk_err_slip: assert property (CTRL_SLIP [*2] |-> ERROR_LED)
      else $error("error led");
   chk_test_steady: assert property (PATTERN_SENDING || REMOTE_LOOPUP |=> TEST_LED)
      else $error("test led");
   chk_loop_start: assert property (TERM_LOOP_START |-> s_loop_go)
      else $error("loop start");
   chk_loop_end: assert property (TERM_LOOP_END && !TERM_LOOP_START
      |=> !TERM_LOOP_ACTIVE) else $error("loop end");
   chk_loop_no_timeout_setting: assert property (cfg_reg[3:0] == 4'h9 && !TERM_LOOP_END
      && TERM_LOOP_ACTIVE |=> TERM_LOOP_ACTIVE) else $error("loop held");
   chk_clk_invert: assert property (TX_CLK_OUT == (OWN_TX_CLK ^ cfg_reg[5]))
      else $error("clock invert");
endmodule // panel_checker
bind front_panel_indicator_control panel_checker i_panel_checker (
   .CLK(CLK),
   .RESETN(RESETN),
   .WR(WR),
   .LINK_UP(LINK_UP),
   .SLOT_ACTIVE(SLOT_ACTIVE),
   .TX_BIT(TX_BIT),
   .CTRL_SLIP(CTRL_SLIP),
   .PATTERN_SENDING(PATTERN_SENDING),
   .REMOTE_LOOPUP(REMOTE_LOOPUP),
   .TERM_LOOP_START(TERM_LOOP_START),
   .TERM_LOOP_END(TERM_LOOP_END),
   .OWN_TX_CLK(OWN_TX_CLK),
   .LINK_LED(LINK_LED),
   .TX_GREEN(TX_GREEN),
   .TX_ORANGE(TX_ORANGE),
   .RX_GREEN(RX_GREEN),
   .RX_ORANGE(RX_ORANGE),
   .ERROR_LED(ERROR_LED),
   .TEST_LED(TEST_LED),
   .TERM_LOOP_ACTIVE(TERM_LOOP_ACTIVE),
   .TX_CLK_OUT(TX_CLK_OUT),
   .ADDR(ADDR),
   .WDATA(WDATA)
);

// ---- testbench/dte_clock_model.sv ----
// Behavioural DTE side: the unit's transmit clock and the external clock
module dte_clock_model (
   output logic own_clk,
   output logic ext_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   // Antiphase, so a wrong clock select can no_timeout_setting pass unseen
   assign ext_clk = ~own_clk;
   initial
   begin
      own_clk = 1'h0;
      forever #324 own_clk = ~own_clk;
   end
endmodule // dte_clock_model

// ---- testbench/front_panel_indicator_control_tb_top.sv ----
// Self-checking bench for the front panel indicator controller
module front_panel_indicator_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'h0, RESETN = 1'h0, WR = 1'h0, RD = 1'h0, LINK_UP = 1'h0, TX_BIT = 1'h0;
   logic SLOT_ACTIVE = 1'h0, RX_BIT = 1'h0, BLUE_ALARM = 1'h0, YELLOW_ALARM = 1'h0;
   logic OUT_OF_FRAME = 1'h0, SYNC_LOSS = 1'h0, FRAME_LOSS = 1'h0, CTRL_SLIP = 1'h0;
   logic FRAMING_BIT_ERR = 1'h0, EXCESS_ZEROS = 1'h0, SEVERE_FRAME_ERR = 1'h0;
   logic PATTERN_SENDING = 1'h0, PATTERN_MISMATCH = 1'h0, ERR_INSERT = 1'h0;
   logic LOCAL_LOOP = 1'h0, REMOTE_LOOP = 1'h0, REMOTE_LOOPUP = 1'h0;
   logic TERM_LOOP_START = 1'h0, TERM_LOOP_END = 1'h0;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic [7:0] RDATA, got;
   logic LINK_LED, TX_GREEN, TX_ORANGE, RX_GREEN, RX_ORANGE, ALARM_LED, ERROR_LED;
   logic TEST_LED, TERM_LOOP_ACTIVE, TX_SAMPLE_CLK, TX_CLK_OUT, EXT_TX_CLK, OWN_TX_CLK;
   int num_errors = 0;
   int samples_checked = 0;
   front_panel_indicator_control i_front_panel_indicator_control (
      .CLK(CLK),
      .RESETN(RESETN),
      .ADDR(ADDR),
      .WDATA(WDATA),
      .WR(WR),
      .RD(RD),
      .RDATA(RDATA),
      .LINK_UP(LINK_UP),
      .SLOT_ACTIVE(SLOT_ACTIVE),
      .TX_BIT(TX_BIT),
      .RX_BIT(RX_BIT),
      .BLUE_ALARM(BLUE_ALARM),
      .YELLOW_ALARM(YELLOW_ALARM),
      .OUT_OF_FRAME(OUT_OF_FRAME),
      .SYNC_LOSS(SYNC_LOSS),
      .FRAME_LOSS(FRAME_LOSS),
      .FRAMING_BIT_ERR(FRAMING_BIT_ERR),
      .EXCESS_ZEROS(EXCESS_ZEROS),
      .CTRL_SLIP(CTRL_SLIP),
      .SEVERE_FRAME_ERR(SEVERE_FRAME_ERR),
      .PATTERN_SENDING(PATTERN_SENDING),
      .PATTERN_MISMATCH(PATTERN_MISMATCH),
      .ERR_INSERT(ERR_INSERT),
      .LOCAL_LOOP(LOCAL_LOOP),
      .REMOTE_LOOP(REMOTE_LOOP),
      .REMOTE_LOOPUP(REMOTE_LOOPUP),
      .TERM_LOOP_START(TERM_LOOP_START),
      .TERM_LOOP_END(TERM_LOOP_END),
      .EXT_TX_CLK(EXT_TX_CLK),
      .OWN_TX_CLK(OWN_TX_CLK),
      .LINK_LED(LINK_LED),
      .TX_GREEN(TX_GREEN),
      .TX_ORANGE(TX_ORANGE),
      .RX_GREEN(RX_GREEN),
      .RX_ORANGE(RX_ORANGE),
      .ALARM_LED(ALARM_LED),
      .ERROR_LED(ERROR_LED),
      .TEST_LED(TEST_LED),
      .TERM_LOOP_ACTIVE(TERM_LOOP_ACTIVE),
      .TX_SAMPLE_CLK(TX_SAMPLE_CLK),
      .TX_CLK_OUT(TX_CLK_OUT)
   );
   dte_clock_model i_dte_clock_model (.own_clk(OWN_TX_CLK), .ext_clk(EXT_TX_CLK));
   initial
      forever #25 CLK = ~CLK;
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Sample off the edge, where the partner clocks no_timeout_setting move
   task automatic tick(int n);
      repeat (n) @(posedge CLK);
      #2;
   endtask
   task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= w;
      RD <= !w;
      @(posedge CLK);
      {WR, RD} <= 2'h0;
      #2 got = RDATA;
   endtask
   task automatic t_link_bits();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge CLK);
         {LINK_UP, SLOT_ACTIVE, TX_BIT, RX_BIT} <= {i[0], i[1], i[0], !i[0]};
         tick(2);
         check("link", LINK_LED, i[0]);
         check("tx", {TX_GREEN, TX_ORANGE}, {i[1] & i[0], i[1] & !i[0]});
         check("rx", {RX_GREEN, RX_ORANGE}, {i[1] & !i[0], i[1] & i[0]});
      end
   endtask
   task automatic t_alarm_err();
      for (int k = 0; k < 6; k++)
      begin
         @(posedge CLK);
         {FRAME_LOSS, SYNC_LOSS, OUT_OF_FRAME, YELLOW_ALARM, BLUE_ALARM} <= 5'h01 << k;
         {SEVERE_FRAME_ERR, CTRL_SLIP, EXCESS_ZEROS, FRAMING_BIT_ERR} <= 4'h1 << k;
         {PATTERN_SENDING, PATTERN_MISMATCH} <= {k > 3, k == 4};
         tick(3);
         check("alarm", ALARM_LED, k < 5);
         check("error", ERROR_LED, k < 5);
         check("test", TEST_LED, k > 3);
      end
      bus(1'h0, 4'h3, 8'h00);
      check("count", got, 8'h01);
      bus(1'h1, 4'h1, 8'h02);
      bus(1'h0, 4'h3, 8'h00);
      check("count", got, 8'h00);
   endtask
   // Early in the blink frame, so the brief pulses are showing
   task automatic t_test_modes();
      for (int m = 0; m < 6; m++)
      begin
         @(posedge CLK);
         {PATTERN_SENDING, ERR_INSERT, REMOTE_LOOPUP, REMOTE_LOOP, LOCAL_LOOP} <= 5'h01 << m;
         tick(2);
         check("test", TEST_LED, !m[0]);
         check("error", ERROR_LED, m == 3);
      end
   endtask
   task automatic t_config_loop();
      bus(1'h0, 4'h0, 8'h00);
      check("config", got, 8'h03);
      bus(1'h0, 4'hF, 8'h00);
      check("unmapped", got, 8'h00);
      bus(1'h1, 4'h0, 8'h39);
      bus(1'h0, 4'h0, 8'h00);
      check("config", got, 8'h39);
      check("sample clk", TX_SAMPLE_CLK, OWN_TX_CLK);
      check("clk out", TX_CLK_OUT, !OWN_TX_CLK);
      @(posedge CLK) TERM_LOOP_START <= 1'h1;
      @(posedge CLK) TERM_LOOP_START <= 1'h0;
      tick(2000);
      check("loop held", TERM_LOOP_ACTIVE, 1'h1);
      bus(1'h0, 4'h2, 8'h00);
      check("status", got, 8'h81);
      bus(1'h0, 4'h4, 8'h00);
      check("loop minutes", got, 8'h00);
      @(posedge CLK) TERM_LOOP_END <= 1'h1;
      @(posedge CLK) TERM_LOOP_END <= 1'h0;
      tick(2);
      check("loop end", TERM_LOOP_ACTIVE, 1'h0);
      bus(1'h1, 4'h1, 8'h01);
      bus(1'h0, 4'h0, 8'h00);
      check("defaults", got, 8'h03);
      check("sample clk", TX_SAMPLE_CLK, EXT_TX_CLK);
   endtask
   // Mid-run reset: registered outputs drop at once and the configuration returns to its default
   task automatic t_reset_mid();
      bus(1'h1, 4'h0, 8'h12);
      check("clk out", TX_CLK_OUT, OWN_TX_CLK);
      check("sample clk", TX_SAMPLE_CLK, OWN_TX_CLK);
      @(posedge CLK) TERM_LOOP_START <= 1'h1;
      @(posedge CLK) TERM_LOOP_START <= 1'h0;
      @(posedge CLK) RESETN <= 1'h0;
      tick(2);
      check("reset link", LINK_LED, 1'h0);
      check("reset loop", TERM_LOOP_ACTIVE, 1'h0);
      @(posedge CLK) RESETN <= 1'h1;
      tick(3);
      bus(1'h0, 4'h0, 8'h00);
      check("reset config", got, 8'h03);
      check("relink", LINK_LED, 1'h1);
      check("sample clk", TX_SAMPLE_CLK, EXT_TX_CLK);
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge CLK);
      RESETN <= 1'h1;
      tick(3);
      t_link_bits();
      t_alarm_err();
      t_test_modes();
      t_config_loop();
      t_reset_mid();
      print_verdict();
   end
   initial
   begin
      #1000000;
      num_errors++;
      print_verdict();
   end
endmodule // front_panel_indicator_control_tb_top
